// >>> common/rtdc_pkg.sv
// Shared constants and carrier types for the compensation and daylight saving control block.
// Assumes the I2C protocol engine, the calendar and the analog trim logic sit outside this block.

package rtdc_pkg;

   // ************************************************************
   // Register offsets on the byte register port
   // ************************************************************
   localparam logic [7:0] ADDR_INIT_TRIM = 8'h0b;
   localparam logic [7:0] ADDR_CURVE     = 8'h0c;
   localparam logic [7:0] ADDR_COMP_CTRL = 8'h0d;
   localparam logic [7:0] ADDR_FWD_MONTH = 8'h15;
   localparam logic [7:0] ADDR_FWD_WDAY  = 8'h16;
   localparam logic [7:0] ADDR_FWD_DATE  = 8'h17;
   localparam logic [7:0] ADDR_FWD_HOUR  = 8'h18;
   localparam logic [7:0] ADDR_REV_MONTH = 8'h19;
   localparam logic [7:0] ADDR_REV_WDAY  = 8'h1a;
   localparam logic [7:0] ADDR_REV_DATE  = 8'h1b;
   localparam logic [7:0] ADDR_REV_HOUR  = 8'h1c;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CC_TSE_BIT   = 7;
   localparam int CC_BAT_LSB   = 5;
   localparam int CC_COEF_W    = 5;
   localparam int DST_EN_BIT   = 7;
   localparam int WD_SEL_BIT   = 6;
   localparam int WD_WEEK_LSB  = 3;
   localparam logic [2:0] WD_LAST_WEEK = 3'h7;
   localparam logic [1:0] BAT_COMP_OFF = 2'h0;
   localparam int DST_BANK_DEPTH = 8;

   // ************************************************************
   // Reset values and periods
   // ************************************************************
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [9:0] TEMP_RESET   = 10'h000;
   localparam int COMP_PERIOD_S = 60;
   localparam int COMP_CNT_W    = 6;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      DST_STANDARD = 2'b01,
      DST_FORWARD  = 2'b10
   } rtdc_dst_type;

   // One byte request from the serial engine; write pulses on the data acknowledge.
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } rtdc_regreq_type;

   // Factory trim levels, stable once power is up.
   typedef struct packed {
      logic [4:0] coef;
      logic [7:0] initTrim;
      logic [7:0] curve;
   } rtdc_trim_type;

   // Current calendar in BCD as kept by the timekeeping logic.
   typedef struct packed {
      logic [4:0] month;
      logic [5:0] date;
      logic [2:0] dow;
      logic [2:0] week;
      logic       lastWeek;
      logic [5:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
   } rtdc_cal_type;

endpackage

// >>> design/rtdc_pin_sync.sv
// Three-stage synchroniser for asynchronous pin levels.
// Assumes the pins change slowly compared with the core clock.

`timescale 1ns/1ps

module rtdc_pin_sync #(
   parameter int W = 2
) (
   // Clock and reset.
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   // Raw pins and the filtered levels.
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } rtdc_sync_state_type;

   rtdc_sync_state_type q;
   rtdc_sync_state_type d;

   // A bit changes only once the second and third stages agree; the first stage feeds only the second.
   always_comb begin
      d     = q;
      d.s1  = pinIn;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
   end

   // State register.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.lvl;

endmodule

// >>> design/rtdc_dst_bank.sv
// Storage for the daylight saving setting bytes, all visible at once to the match logic.
// Assumes the writer gives an index already range checked.

`timescale 1ns/1ps

module rtdc_dst_bank #(
   parameter int DEPTH = 8,
   parameter int W     = 8
) (
   // Clock and reset.
   input  wire logic                        core_clk,
   input  wire logic                        arst_n,
   // Write port.
   input  wire logic                        wrEn,
   input  wire logic [$clog2(DEPTH)-1:0]    wrIdx,
   input  wire logic [W-1:0]                wrData,
   // Whole contents.
   output logic      [DEPTH-1:0][W-1:0]     bytes
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
   } rtdc_bank_state_type;

   rtdc_bank_state_type q;
   rtdc_bank_state_type d;

   // One byte is replaced per write.
   always_comb begin
      d = q;
      if (wrEn) begin
         d.mem[wrIdx] = wrData;
      end
   end

   // State register; settings start cleared so nothing fires before software sets them.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bytes = q.mem;

endmodule

// >>> design/rtdc_core.sv
// Compensation control and automatic daylight saving change logic of a real time clock.
// Assumes a serial engine delivering byte requests, a calendar on this clock, and an analog trim block.

`timescale 1ns/1ps

module rtdc_core #(
   parameter int PERIOD_S = rtdc_pkg::COMP_PERIOD_S
) (
   // Clock and reset.
   input  wire logic                      core_clk,
   input  wire logic                      arst_n,
   // Byte register port from the serial engine.
   input  wire rtdc_pkg::rtdc_regreq_type regReq,
   output logic [7:0]                     regRdData,
   // Factory trims and asynchronous pins.
   input  wire rtdc_pkg::rtdc_trim_type   factoryTrim,
   input  wire logic                      secTickPin,
   input  wire logic                      mainPowerPin,
   // Calendar and temperature sensor on this clock.
   input  wire rtdc_pkg::rtdc_cal_type    cal,
   input  wire logic                      tempDone,
   input  wire logic [9:0]                tempCode,
   // Controls to the analog trim block.
   output logic                           compStart,
   output logic                           trimLoad,
   output logic                           tempSenseEnable,
   output logic [1:0]                     batteryCompMode,
   output logic [4:0]                     trimCoefficient,
   // Calendar adjust requests and status.
   output logic                           advanceHour,
   output logic                           retardHour,
   output logic                           forwardAdjustFlag
);

   // ************************************************************
   // State
   // ************************************************************
   // Trims are held here rather than read live, so a drifting input cannot move them after power-up.
   typedef struct packed {
      logic                        loaded;
      logic [7:0]                  compCtrl;
      logic [7:0]                  initTrim;
      logic [7:0]                  curve;
      logic [rtdc_pkg::COMP_CNT_W-1:0] secCnt;
      logic                        secLvl;
      logic                        compStart;
      logic                        busy;
      logic [9:0]                  tempLast;
      logic                        tempKnown;
      logic                        trimLoad;
      rtdc_pkg::rtdc_dst_type      dst;
      logic                        advance;
      logic                        retard;
      logic [7:0]                  rdData;
   } rtdc_core_state_type;

   rtdc_core_state_type q;
   rtdc_core_state_type d;

   logic [1:0]                                  pinLvl;
   logic [rtdc_pkg::DST_BANK_DEPTH-1:0][7:0]    dstBytes;
   logic                                        bankWr;
   logic [2:0]                                  bankIdx;
   logic [7:0]                                  bankOff;

   // ************************************************************
   // Submodules
   // ************************************************************

   // Tick and power detect come from the crystal and supply domains.
   rtdc_pin_sync #(
      .W (2)
   ) u_sync (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .pinIn    ({mainPowerPin, secTickPin}),
      .level    (pinLvl)
   );

   // offsets come from the serial engine once the identifier matched.
   // Setting bytes, indexed from the forward month offset.
   assign bankOff = regReq.addr - rtdc_pkg::ADDR_FWD_MONTH;
   assign bankIdx = bankOff[2:0];
   // The read-only trim bytes sit below this range, so the bank never sees them.
   // write on acknowledge
   assign bankWr  = regReq.write && regReq.addr >= rtdc_pkg::ADDR_FWD_MONTH
                    && regReq.addr <= rtdc_pkg::ADDR_REV_HOUR;

   rtdc_dst_bank #(
      .DEPTH (rtdc_pkg::DST_BANK_DEPTH),
      .W     (8)
   ) u_bank (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .wrEn     (bankWr),
      .wrIdx    (bankIdx),
      .wrData   (regReq.data),
      .bytes    (dstBytes)
   );

   // ************************************************************
   // Matching of a change time
   // ************************************************************

   // True when the calendar sits on the programmed month, day and hour.
   function automatic logic dst_match(input logic [7:0] mon, input logic [7:0] wd, input logic [7:0] dt,
                                      input logic [7:0] hr, input rtdc_pkg::rtdc_cal_type c);
      logic [2:0] wk;
      logic       weekOk;
      logic       dayOk;
      wk = wd[rtdc_pkg::WD_WEEK_LSB +: 3];
      weekOk = (wk == rtdc_pkg::WD_LAST_WEEK) ? c.lastWeek : (wk == c.week);
      dayOk = wd[rtdc_pkg::WD_SEL_BIT] ? (weekOk && wd[2:0] == c.dow) : (dt[5:0] == c.date);
      return (mon[4:0] == c.month) && dayOk && (hr[5:0] == c.hour);
   endfunction

   logic dstEnable;
   logic fwdMatch;
   logic revMatch;
   logic secRise;
   logic hourTop;
   logic compWrite;
   logic compRun;
   logic vddOk;

   assign dstEnable = dstBytes[0][rtdc_pkg::DST_EN_BIT];
   assign fwdMatch  = dst_match(dstBytes[0], dstBytes[1], dstBytes[2], dstBytes[3], cal);
   assign revMatch  = dst_match(dstBytes[4], dstBytes[5], dstBytes[6], dstBytes[7], cal);
   // Pin levels arrive four edges after the pins move; a tick rise lasts one edge here.
   assign vddOk     = pinLvl[1];
   assign secRise   = pinLvl[0] & ~q.secLvl;
   // Changes fire on the tick that starts the hour, so each fires once.
   assign hourTop   = secRise && cal.minute == 7'h00 && cal.second == 7'h00;
   assign compWrite = regReq.write && regReq.addr == rtdc_pkg::ADDR_COMP_CTRL;
   assign compRun   = q.compCtrl[rtdc_pkg::CC_TSE_BIT]
                      && (vddOk || q.compCtrl[rtdc_pkg::CC_BAT_LSB +: 2] != rtdc_pkg::BAT_COMP_OFF);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d           = q;
      d.compStart = 1'b0;
      d.trimLoad  = 1'b0;
      d.advance   = 1'b0;
      d.retard    = 1'b0;
      d.secLvl    = pinLvl[0];

      // capture factory trims once after reset release
      if (!q.loaded) begin
         d.loaded                           = 1'b1;
         d.compCtrl[rtdc_pkg::CC_COEF_W-1:0] = factoryTrim.coef;
         d.initTrim                         = factoryTrim.initTrim;
         d.curve                            = factoryTrim.curve;
      end

      // only control bits take a write
      if (compWrite) begin
         d.compCtrl[7:rtdc_pkg::CC_BAT_LSB] = regReq.data[7:rtdc_pkg::CC_BAT_LSB];
      end
      // no write path exists for the read-only trim bytes.

      // sixty second period
      // The count restarts when compensation stops, so a fresh start waits a full period.
      if (!compRun) begin
         d.secCnt = '0;
      end else if (secRise) begin
         if (q.secCnt == rtdc_pkg::COMP_CNT_W'(PERIOD_S - 1)) begin
            d.secCnt    = '0;
            d.compStart = 1'b1;
         end else begin
            d.secCnt = q.secCnt + 1'b1;
         end
      end

      if (compWrite && regReq.data[rtdc_pkg::CC_TSE_BIT]) begin
         d.compStart = 1'b1;
         d.secCnt    = '0;
      end

      // load only on change
      // A conversion end with nothing pending is ignored, so a stray pulse cannot load trims.
      if (tempDone && q.busy) begin
         d.busy = 1'b0;
         if (!q.tempKnown || tempCode != q.tempLast) begin
            d.trimLoad  = 1'b1;
            d.tempLast  = tempCode;
            d.tempKnown = 1'b1;
         end
      end
      // A new start while a conversion is pending simply keeps the sensor busy.
      if (d.compStart) begin
         d.busy = 1'b1;
      end

      // automatic forward and reverse change
      // Clearing the enable drops the flag without asking the calendar for any change.
      unique case (q.dst)
         rtdc_pkg::DST_STANDARD: begin
            if (dstEnable && hourTop && fwdMatch) begin
               d.dst     = rtdc_pkg::DST_FORWARD;
               d.advance = 1'b1;
            end
         end
         rtdc_pkg::DST_FORWARD: begin
            if (!dstEnable) begin
               d.dst = rtdc_pkg::DST_STANDARD;
            end else if (hourTop && revMatch) begin
               d.dst    = rtdc_pkg::DST_STANDARD;
               d.retard = 1'b1;
            end
         end
         default: begin
            d.dst = rtdc_pkg::DST_STANDARD;
         end
      endcase

      // read back device-held values
      // Read data is registered, so it lags the offset by one edge.
      unique case (regReq.addr)
         rtdc_pkg::ADDR_INIT_TRIM: d.rdData = q.initTrim;
         rtdc_pkg::ADDR_CURVE:     d.rdData = q.curve;
         rtdc_pkg::ADDR_COMP_CTRL: d.rdData = q.compCtrl;
         default: begin
            d.rdData = bankWr || (regReq.addr >= rtdc_pkg::ADDR_FWD_MONTH && regReq.addr <= rtdc_pkg::ADDR_REV_HOUR)
                       ? dstBytes[bankIdx] : rtdc_pkg::BYTE_RESET;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q.loaded    <= 1'b0;
         q.compCtrl  <= rtdc_pkg::BYTE_RESET;
         q.initTrim  <= rtdc_pkg::BYTE_RESET;
         q.curve     <= rtdc_pkg::BYTE_RESET;
         q.secCnt    <= '0;
         q.secLvl    <= 1'b0;
         q.compStart <= 1'b0;
         q.busy      <= 1'b0;
         q.tempLast  <= rtdc_pkg::TEMP_RESET;
         q.tempKnown <= 1'b0;
         q.trimLoad  <= 1'b0;
         q.dst       <= rtdc_pkg::DST_STANDARD;
         q.advance   <= 1'b0;
         q.retard    <= 1'b0;
         q.rdData    <= rtdc_pkg::BYTE_RESET;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs, all from flip-flops
   // ************************************************************

   // flag only from state machine
   // The forward state is the high bit of the one-hot code, so the flag is a bare flop.
   assign forwardAdjustFlag = q.dst[1];
   assign regRdData         = q.rdData;
   assign compStart         = q.compStart;
   assign trimLoad          = q.trimLoad;
   assign tempSenseEnable   = q.compCtrl[rtdc_pkg::CC_TSE_BIT];
   assign batteryCompMode   = q.compCtrl[rtdc_pkg::CC_BAT_LSB +: 2];
   assign trimCoefficient   = q.compCtrl[rtdc_pkg::CC_COEF_W-1:0];
   assign advanceHour       = q.advance;
   assign retardHour        = q.retard;

endmodule

// >>> verification/rtdc_core_chk.sv
// Checker for the compensation and daylight saving control block.
// Assumes it sees only the top module ports, attached by the bind below.
`timescale 1ns/1ps
module rtdc_core_chk #(
   parameter int PERIOD_S = 60
) (
   // Clock and reset.
   input wire logic                      core_clk,
   input wire logic                      arst_n,
   // Register port and side inputs.
   input wire rtdc_pkg::rtdc_regreq_type regReq,
   input wire logic [7:0]                regRdData,
   input wire rtdc_pkg::rtdc_trim_type   factoryTrim,
   input wire rtdc_pkg::rtdc_cal_type    cal,
   input wire logic                      tempDone,
   // Outputs under watch.
   input wire logic                      compStart,
   input wire logic                      trimLoad,
   input wire logic                      tempSenseEnable,
   input wire logic [1:0]                batteryCompMode,
   input wire logic [4:0]                trimCoefficient,
   input wire logic                      advanceHour,
   input wire logic                      retardHour,
   input wire logic                      forwardAdjustFlag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Decoded writes, kept apart so each property reads plainly.
   wire logic ccWr  = regReq.write && regReq.addr == rtdc_pkg::ADDR_COMP_CTRL;
   wire logic monWr = regReq.write && regReq.addr == rtdc_pkg::ADDR_FWD_MONTH;

   chk_write_starts: assert property (ccWr && regReq.data[7] |=> compStart)
      else $error("sense enable write gave no start pulse");
   chk_ctrl_update: assert property (ccWr |=> tempSenseEnable == $past(regReq.data[7])
      && batteryCompMode == $past(regReq.data[6:5])) else $error("control bits not taken");
   chk_coef_locked: assert property ($past(arst_n) |-> trimCoefficient == factoryTrim.coef)
      else $error("coefficient differs from factory value");
   chk_ro_readback: assert property (regReq.addr == rtdc_pkg::ADDR_CURVE && $past(arst_n)
      |=> regRdData == factoryTrim.curve) else $error("read-only byte changed");
   chk_unmapped_zero: assert property (regReq.addr == 8'h20 |=> regRdData == 8'h00)
      else $error("unmapped byte not zero");
   chk_flag_sets: assert property (advanceHour |-> forwardAdjustFlag && !$past(forwardAdjustFlag))
      else $error("forward change without flag rise");
   chk_flag_clears: assert property (retardHour |-> !forwardAdjustFlag && $past(forwardAdjustFlag))
      else $error("reverse change without flag fall");
   chk_flag_source: assert property ($rose(forwardAdjustFlag) |-> advanceHour)
      else $error("flag rose without forward change");
   chk_enable_clear: assert property (monWr && !regReq.data[7] |=> ##1 !forwardAdjustFlag)
      else $error("flag kept after enable cleared");
   chk_trim_cause: assert property (trimLoad |-> $past(tempDone))
      else $error("trim load without conversion end");
   chk_change_top: assert property (advanceHour || retardHour |-> $past(cal.minute) == 7'h00
      && $past(cal.second) == 7'h00) else $error("change off the hour");

   cover property (advanceHour);
   cover property (retardHour);
   cover property (trimLoad);
endmodule

bind rtdc_core rtdc_core_chk #(.PERIOD_S(PERIOD_S)) u_chk (
   .core_clk(core_clk), .arst_n(arst_n), .regReq(regReq), .regRdData(regRdData),
   .factoryTrim(factoryTrim), .cal(cal), .tempDone(tempDone), .compStart(compStart),
   .trimLoad(trimLoad), .tempSenseEnable(tempSenseEnable), .batteryCompMode(batteryCompMode),
   .trimCoefficient(trimCoefficient), .advanceHour(advanceHour), .retardHour(retardHour),
   .forwardAdjustFlag(forwardAdjustFlag)
);

// >>> verification/rtdc_host_model.sv
// Host side of the byte register port, as left by the serial engine.
// Assumes the identifier byte was matched upstream, so only offsets and data arrive here.
`timescale 1ns/1ps
module rtdc_host_model (
   // Clock.
   input wire logic                  core_clk,
   // Requests and answers.
   output rtdc_pkg::rtdc_regreq_type regReq,
   input wire logic [7:0]            regRdData
);
   initial regReq = '0;
   // write pulse stands for the data acknowledge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regReq <= '{write: 1'b1, addr: a, data: d};
      @(posedge core_clk);
      regReq.write <= 1'b0;
   endtask
   // Data is taken two edges on, since it stands while the offset is held.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regReq.addr <= a;
      repeat (2) @(posedge core_clk);
      #1 d = regRdData;
   endtask
   // read, keep low five bits, add control bits.
   task automatic enable_comp(input logic [7:0] ctrl);
      logic [7:0] v;
      rd(rtdc_pkg::ADDR_COMP_CTRL, v);
      wr(rtdc_pkg::ADDR_COMP_CTRL, (v & 8'h1f) | (ctrl & 8'he0));
   endtask
endmodule

// >>> verification/test_rtdc_core.sv
// Self-checking bench for the compensation and daylight saving control block.
// Assumes a shortened compensation period and a host model on the register port.
`timescale 1ns/1ps
module test_rtdc_core;
   localparam int PER = 3;
   localparam rtdc_pkg::rtdc_trim_type TRIM = '{coef: 5'h15, initTrim: 8'h3c, curve: 8'ha7};
   logic                      core_clk = 1'b0;
   logic                      arst_n = 1'b0;
   logic                      secTickPin = 1'b0;
   logic                      mainPowerPin = 1'b1;
   logic                      tempDone = 1'b0;
   logic [9:0]                tempCode = '0;
   rtdc_pkg::rtdc_cal_type    cal = '0;
   rtdc_pkg::rtdc_trim_type   factoryTrim = TRIM;
   rtdc_pkg::rtdc_regreq_type regReq;
   logic [7:0]                regRdData, v;
   logic                      compStart, trimLoad, temp_sense_enable, advanceHour, retardHour, flag;
   logic [1:0]                batMode;
   logic [4:0]                coef;
   int miscompares = 0, checked = 0, nStart = 0, nLoad = 0, nAdv = 0, nRet = 0, n0;
   logic [7:0] dstVal [8] = '{8'h84, 8'h48, 8'h00, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02};

   always #20 core_clk = ~core_clk;
   // Pulse tallies, so scenarios judge by difference.
   always @(posedge core_clk) begin
      nStart += int'(compStart === 1'b1);
      nLoad  += int'(trimLoad === 1'b1);
      nAdv   += int'(advanceHour === 1'b1);
      nRet   += int'(retardHour === 1'b1);
   end

   rtdc_host_model host (.core_clk(core_clk), .regReq(regReq), .regRdData(regRdData));
   rtdc_core #(.PERIOD_S(PER)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .regReq(regReq), .regRdData(regRdData),
      .factoryTrim(factoryTrim), .secTickPin(secTickPin), .mainPowerPin(mainPowerPin),
      .cal(cal), .tempDone(tempDone), .tempCode(tempCode), .compStart(compStart),
      .trimLoad(trimLoad), .tempSenseEnable(temp_sense_enable), .batteryCompMode(batMode),
      .trimCoefficient(coef), .advanceHour(advanceHour), .retardHour(retardHour),
      .forwardAdjustFlag(flag));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One second tick; the rise reaches the logic four edges later.
   task automatic tick();
      @(posedge core_clk) secTickPin <= 1'b1;
      repeat (8) @(posedge core_clk);
      secTickPin <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic done_pulse(input logic [9:0] c);
      @(posedge core_clk) {tempDone, tempCode} <= {1'b1, c};
      @(posedge core_clk) tempDone <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic test_regs();
      host.rd(rtdc_pkg::ADDR_INIT_TRIM, v); chk8(v, TRIM.initTrim);
      host.wr(rtdc_pkg::ADDR_INIT_TRIM, 8'hff);
      host.wr(rtdc_pkg::ADDR_CURVE, 8'h00);
      host.wr(rtdc_pkg::ADDR_COMP_CTRL, 8'h0a);
      host.wr(8'h20, 8'h5a);
      host.rd(rtdc_pkg::ADDR_INIT_TRIM, v); chk8(v, TRIM.initTrim);
      host.rd(rtdc_pkg::ADDR_CURVE, v); chk8(v, TRIM.curve);
      host.rd(rtdc_pkg::ADDR_COMP_CTRL, v); chk8(v, {3'h0, TRIM.coef});
      host.rd(8'h20, v); chk8(v, 8'h00);
      $display("test regs done");
   endtask

   task automatic test_comp();
      n0 = nStart;
      host.enable_comp(8'he0);
      repeat (2) @(posedge core_clk);
      chk8(8'(nStart - n0), 8'h01);
      chk8({temp_sense_enable, batMode, coef}, {3'h7, TRIM.coef});
      n0 = nLoad;
      done_pulse(10'h155);
      chk8(8'(nLoad - n0), 8'h01);
      host.wr(rtdc_pkg::ADDR_COMP_CTRL, 8'he0);
      done_pulse(10'h155);
      chk8(8'(nLoad - n0), 8'h01);
      host.wr(rtdc_pkg::ADDR_COMP_CTRL, 8'he0);
      done_pulse(10'h156);
      chk8(8'(nLoad - n0), 8'h02);
      $display("test comp done");
   endtask

   task automatic test_period();
      n0 = nStart;
      repeat (PER - 1) tick();
      chk8(8'(nStart - n0), 8'h00);
      tick();
      chk8(8'(nStart - n0), 8'h01);
      host.enable_comp(8'h80);
      @(posedge core_clk) mainPowerPin <= 1'b0;
      repeat (6) @(posedge core_clk);
      n0 = nStart;
      repeat (PER) tick();
      chk8(8'(nStart - n0), 8'h00);
      // Any battery mode but off keeps the period running without main power.
      host.enable_comp(8'ha0);
      repeat (2) @(posedge core_clk);
      n0 = nStart;
      repeat (PER) tick();
      chk8(8'(nStart - n0), 8'h01);
      @(posedge core_clk) mainPowerPin <= 1'b1;
      repeat (6) @(posedge core_clk);
      $display("test period done");
   endtask

   task automatic set_cal(input logic [4:0] m, input logic [2:0] wk, input logic last);
      @(posedge core_clk);
      cal <= '{month: m, date: 6'h00, dow: 3'h0, week: wk, lastWeek: last,
               hour: 6'h02, minute: 7'h00, second: 7'h00};
   endtask

   task automatic test_dst();
      for (int i = 0; i < 8; i++) begin
         host.wr(8'h15 + 8'(i), dstVal[i]);
         host.rd(8'h15 + 8'(i), v); chk8(v, dstVal[i]);
      end
      chk8({7'h0, flag}, 8'h00);
      set_cal(5'h04, 3'h1, 1'b0);
      tick();
      chk8(8'(nAdv), 8'h01);
      chk8({7'h0, flag}, 8'h01);
      tick();
      chk8(8'(nAdv), 8'h01);
      set_cal(5'h10, 3'h4, 1'b1);
      tick();
      chk8(8'(nRet), 8'h01);
      chk8({7'h0, flag}, 8'h00);
      set_cal(5'h04, 3'h1, 1'b0);
      tick();
      chk8({7'h0, flag}, 8'h01);
      host.wr(rtdc_pkg::ADDR_FWD_MONTH, 8'h04);
      @(posedge core_clk) #1;
      chk8({7'h0, flag}, 8'h00);
      tick();
      chk8(8'(nAdv), 8'h02);
      $display("test dst done");
   endtask

   // Watchdog: a hang counts against the run.
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      test_regs();
      test_comp();
      test_period();
      test_dst();
      finish_test();
   end
endmodule
